// File: hdl/msc_status_top.sv
// microstep table position, phase current readback and chopper protection bits
// assumes the register port, step request and sine table sit on REF_CLK_I
`timescale 1ns/100ps
`include "msc_map.svh"

module msc_status_top #(
  parameter int INTERP_DIV = `MSC_INTERP_DIV
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [`MSC_ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  input wire logic STEP_I,
  input wire logic DIR_I,
  input wire logic [7:0] START_SIN_I,
  input wire logic [7:0] START_SIN90_I,
  input wire logic [`MSC_CUR_W-1:0] TABLE_VAL_A_I,
  input wire logic [`MSC_CUR_W-1:0] TABLE_VAL_B_I,
  output logic [`MSC_POS_W-1:0] TABLE_IDX_A_O,
  output logic [`MSC_POS_W-1:0] TABLE_IDX_B_O,
  output logic [31:0] CHOPPER_CFG_O,
  output logic SUPPLY_SHORT_GUARD_OFF_O,
  output logic GROUND_SHORT_GUARD_OFF_O,
  output logic INTERP_EN_O,
  output logic [3:0] STEP_RES_O
);

  typedef struct packed {
    logic [`MSC_POS_W-1:0] pos;
    logic [`MSC_POS_W-1:0] idx_b;
    logic [`MSC_CUR_W-1:0] phase_a_table_value;
    logic [`MSC_CUR_W-1:0] phase_b_table_value;
    logic moved;
    logic crossed;
    logic [31:0] chop;
    logic [31:0] rdata;
  } msc_top_st_t;

  msc_top_st_t s_q, s_d;
  msc_pkg::msc_reg_req_t req;
  msc_pkg::msc_move_t move;
  logic [`MSC_POS_W:0] pos_up;
  logic [`MSC_POS_W:0] pos_dn;
  logic [`MSC_POS_W-1:0] pos_next;
  logic wrapped;

  assign req = '{addr: REG_ADDR_I, wr: REG_WR_I, wdata: REG_WDATA_I};

  msc_step_gen #(
    .DIV(INTERP_DIV)
  ) u_step_gen (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .step_i(STEP_I),
    .dir_i(DIR_I),
    .res_i(s_q.chop[`MSC_RES_LSB +: 4]),
    .interp_i(s_q.chop[`MSC_INTERP_BIT]),
    .move_o(move)
  );

  // carry out of the 10-bit sum marks a wrap, which always passes zero
  assign pos_up = {1'b0, s_q.pos} + {1'b0, move.width};
  assign pos_dn = {1'b0, s_q.pos} - {1'b0, move.width};
  assign pos_next = move.up ? pos_up[`MSC_POS_W-1:0] : pos_dn[`MSC_POS_W-1:0];
  assign wrapped = move.up ? pos_up[`MSC_POS_W] : pos_dn[`MSC_POS_W];

  always_comb begin
    s_d = s_q;
    s_d.moved = move.mv;
    s_d.crossed = 1'b0;
    if (move.mv) begin
      s_d.pos = pos_next;
      s_d.idx_b = pos_next + `MSC_PHASE_B_OFS;
      s_d.crossed = wrapped || (pos_next == '0);
    end
    // the table answers the new index combinationally, so currents follow one cycle later
    if (s_q.moved) begin
      if (s_q.crossed) begin
        s_d.phase_a_table_value = {1'b0, START_SIN90_I};
        s_d.phase_b_table_value = {1'b0, START_SIN_I};
      end else begin
        s_d.phase_a_table_value = TABLE_VAL_A_I;
        s_d.phase_b_table_value = TABLE_VAL_B_I;
      end
    end
    // only the chopper word is writable; status offsets drop writes
    if (req.wr && req.addr == `MSC_OFS_CHOP_CFG) begin
      s_d.chop = req.wdata & `MSC_CHOP_WMASK;
    end
    case (req.addr)
      `MSC_OFS_TABLE_POS: s_d.rdata = {22'h000000, s_q.pos};
      `MSC_OFS_PHASE_CUR: begin
        s_d.rdata = {7'h00, s_q.phase_a_table_value, 7'h00, s_q.phase_b_table_value};
      end
      `MSC_OFS_CHOP_CFG: s_d.rdata = s_q.chop;
      default: s_d.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_q <= '{pos: '0, idx_b: `MSC_PHASE_B_OFS, phase_a_table_value: `MSC_PHASE_A_TABLE_VALUE_RESET,
               phase_b_table_value: `MSC_PHASE_B_TABLE_VALUE_RESET, moved: 1'b0, crossed: 1'b0,
               chop: `MSC_CHOP_RESET, rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA_O = s_q.rdata;
  assign TABLE_IDX_A_O = s_q.pos;
  assign TABLE_IDX_B_O = s_q.idx_b;
  assign CHOPPER_CFG_O = s_q.chop;
  assign SUPPLY_SHORT_GUARD_OFF_O = s_q.chop[`MSC_SUPPLY_GUARD_BIT];
  assign GROUND_SHORT_GUARD_OFF_O = s_q.chop[`MSC_GROUND_GUARD_BIT];
  assign INTERP_EN_O = s_q.chop[`MSC_INTERP_BIT];
  assign STEP_RES_O = s_q.chop[`MSC_RES_LSB +: 4];

endmodule

// File: hdl/msc_map.svh
// register offsets, field positions, reset values and timing counts of the
// microstep status block; included by the package and the design modules
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

`define MSC_ADDR_W 7
`define MSC_OFS_TABLE_POS 7'h6A
`define MSC_OFS_PHASE_CUR 7'h6B
`define MSC_OFS_CHOP_CFG 7'h6C

`define MSC_POS_W 10
`define MSC_CUR_W 9
`define MSC_PHASE_B_OFS 10'h100

`define MSC_PHASE_A_TABLE_VALUE_LSB 16
`define MSC_PHASE_B_TABLE_VALUE_LSB 0
`define MSC_SUPPLY_GUARD_BIT 31
`define MSC_GROUND_GUARD_BIT 30
`define MSC_INTERP_BIT 28
`define MSC_RES_LSB 24

`define MSC_CHOP_RESET 32'h1041_0150
`define MSC_CHOP_WMASK 32'hFFFD_DFFF
`define MSC_PHASE_A_TABLE_VALUE_RESET 9'h0F7
`define MSC_PHASE_B_TABLE_VALUE_RESET 9'h000
`define MSC_RES_MAX 4'h8

// interpolation tick period in reference clocks
`define MSC_INTERP_DIV 16

`endif

// File: hdl/msc_pkg.sv
// types shared by the microstep status block
// assumes msc_map.svh is on the include path
`include "msc_map.svh"

package msc_pkg;

  typedef struct packed {
    logic [`MSC_ADDR_W-1:0] addr;
    logic wr;
    logic [31:0] wdata;
  } msc_reg_req_t;

  typedef struct packed {
    logic mv;
    logic up;
    logic [`MSC_POS_W-1:0] width;
  } msc_move_t;

  typedef enum logic [1:0] {
    MSC_IDLE = 2'b01,
    MSC_RUN = 2'b10
  } msc_state_t;

  function automatic logic [`MSC_POS_W-1:0] msc_step_width(input logic [3:0] res);
    logic [3:0] r;
    r = (res > `MSC_RES_MAX) ? `MSC_RES_MAX : res;
    return `MSC_POS_W'(1) << r;
  endfunction

endpackage

// File: hdl/msc_step_gen.sv
// step generator: turns coarse step requests into moves of the table position
// assumes step/dir come from logic on the same clock as one-cycle pulses
`timescale 1ns/100ps
`include "msc_map.svh"

module msc_step_gen #(
  parameter int DIV = `MSC_INTERP_DIV
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic [3:0] res_i,
  input wire logic interp_i,
  output msc_pkg::msc_move_t move_o
);

  typedef struct packed {
    msc_pkg::msc_state_t st;
    logic [`MSC_POS_W-1:0] left;
    logic up;
    logic [15:0] div;
    msc_pkg::msc_move_t move;
  } msc_gen_st_t;

  msc_gen_st_t s_q, s_d;
  logic [`MSC_POS_W-1:0] width;
  logic tick;

  assign width = msc_pkg::msc_step_width(res_i);
  assign tick = (s_q.div == 16'(DIV - 1));
  assign move_o = s_q.move;

  always_comb begin
    s_d = s_q;
    s_d.move = '0;
    s_d.div = tick ? 16'h0000 : s_q.div + 16'h0001;
    case (s_q.st)
      msc_pkg::MSC_IDLE: begin
        s_d.div = 16'h0000;
        if (step_i) begin
          if (interp_i && width != `MSC_POS_W'(1)) begin
            s_d.st = msc_pkg::MSC_RUN;
            s_d.left = width;
            s_d.up = dir_i;
          end else begin
            s_d.move = '{mv: 1'b1, up: dir_i, width: width};
          end
        end
      end
      msc_pkg::MSC_RUN: begin
        if (step_i) begin
          // a new coarse step arrives early: finish the old one at once
          s_d.move = '{mv: 1'b1, up: s_q.up, width: s_q.left};
          s_d.left = width;
          s_d.up = dir_i;
          s_d.div = 16'h0000;
          if (!interp_i || width == `MSC_POS_W'(1)) begin
            s_d.st = msc_pkg::MSC_IDLE;
            s_d.left = '0;
          end
        end else if (!interp_i) begin
          s_d.move = '{mv: 1'b1, up: s_q.up, width: s_q.left};
          s_d.st = msc_pkg::MSC_IDLE;
          s_d.left = '0;
        end else if (tick) begin
          s_d.move = '{mv: 1'b1, up: s_q.up, width: `MSC_POS_W'(1)};
          s_d.left = s_q.left - `MSC_POS_W'(1);
          if (s_q.left == `MSC_POS_W'(1)) begin
            s_d.st = msc_pkg::MSC_IDLE;
          end
        end
      end
      default: begin
        s_d.st = msc_pkg::MSC_IDLE;
        s_d.left = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: msc_pkg::MSC_IDLE, left: '0, up: 1'b0, div: 16'h0000, move: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: verification/msc_status_top_asserts.sv
// port checker for the microstep status block
// assumes one clock REF_CLK_I and an async active-low RST_N_I
`timescale 1ns/100ps
module msc_status_top_asserts #(
  parameter int INTERP_DIV = 16
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [6:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic STEP_I,
  input wire logic DIR_I,
  input wire logic [9:0] TABLE_IDX_A_O,
  input wire logic [9:0] TABLE_IDX_B_O,
  input wire logic [31:0] CHOPPER_CFG_O,
  input wire logic SUPPLY_SHORT_GUARD_OFF_O,
  input wire logic GROUND_SHORT_GUARD_OFF_O,
  input wire logic INTERP_EN_O,
  input wire logic [3:0] STEP_RES_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  idx_b_offset_a: assert property (TABLE_IDX_B_O == TABLE_IDX_A_O + 10'h100)
    else $error("phase b index off");
  guard_bits_a: assert property (
    SUPPLY_SHORT_GUARD_OFF_O == CHOPPER_CFG_O[31] &&
    GROUND_SHORT_GUARD_OFF_O == CHOPPER_CFG_O[30]) else $error("guard bit mismatch");
  interp_res_a: assert property (INTERP_EN_O == CHOPPER_CFG_O[28] &&
    STEP_RES_O == CHOPPER_CFG_O[27:24]) else $error("interp or res mismatch");
  cfg_write_a: assert property (REG_WR_I && REG_ADDR_I == 7'h6C |=>
    CHOPPER_CFG_O == ($past(REG_WDATA_I) & 32'hFFFD_DFFF)) else $error("cfg write lost");
  cfg_hold_a: assert property (!(REG_WR_I && REG_ADDR_I == 7'h6C) |=>
    $stable(CHOPPER_CFG_O)) else $error("cfg changed without write");
  pos_read_a: assert property (REG_ADDR_I == 7'h6A |=>
    REG_RDATA_O == {22'h0, $past(TABLE_IDX_A_O)}) else $error("position read wrong");
  cur_read_a: assert property (REG_ADDR_I == 7'h6B |=>
    REG_RDATA_O[31:25] == 7'h0 && REG_RDATA_O[15:9] == 7'h0) else $error("current pad bits");
  gap_read_a: assert property (REG_ADDR_I == 7'h10 |=> REG_RDATA_O == 32'h0)
    else $error("unmapped read nonzero");
  // move is registered twice, so the new position shows two edges after the step
  step_unit_a: assert property (!STEP_I ##1 STEP_I && DIR_I && !INTERP_EN_O &&
    STEP_RES_O == 4'h0 ##1 !STEP_I |-> ##1 TABLE_IDX_A_O == $past(TABLE_IDX_A_O) + 10'h1)
    else $error("single step move wrong");
endmodule
bind msc_status_top msc_status_top_asserts #(.INTERP_DIV(INTERP_DIV)) u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .STEP_I(STEP_I), .DIR_I(DIR_I),
  .TABLE_IDX_A_O(TABLE_IDX_A_O), .TABLE_IDX_B_O(TABLE_IDX_B_O),
  .CHOPPER_CFG_O(CHOPPER_CFG_O), .SUPPLY_SHORT_GUARD_OFF_O(SUPPLY_SHORT_GUARD_OFF_O),
  .GROUND_SHORT_GUARD_OFF_O(GROUND_SHORT_GUARD_OFF_O), .INTERP_EN_O(INTERP_EN_O),
  .STEP_RES_O(STEP_RES_O));

// File: verification/msc_status_top_tb.sv
// self-checking bench for the microstep status block
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/100ps
module msc_status_top_tb;
  logic clk, rst_n, wr, step, dir, sg, gg, ie;
  logic [6:0] addr;
  logic [31:0] wdata, rdata, cfg, d, p;
  logic [9:0] ia, ib;
  logic [3:0] res;
  int n_fail = 0;
  int total_checks = 0;
  // table stand-in: index-dependent so a wrong index shows in the readback
  msc_status_top #(.INTERP_DIV(2)) u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .STEP_I(step), .DIR_I(dir),
    .START_SIN_I(8'h3C), .START_SIN90_I(8'hA5), // never rewritten
    .TABLE_VAL_A_I(ia[8:0] ^ 9'h155), .TABLE_VAL_B_I(ib[8:0]), .TABLE_IDX_A_O(ia),
    .TABLE_IDX_B_O(ib), .CHOPPER_CFG_O(cfg), .SUPPLY_SHORT_GUARD_OFF_O(sg),
    .GROUND_SHORT_GUARD_OFF_O(gg), .INTERP_EN_O(ie), .STEP_RES_O(res));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [31:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    // idle edge so a following write never re-raises the strobe in the same step
    @(posedge clk);
    #1;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [31:0] v);
    addr = a;
    @(posedge clk);
    #1 v = rdata;
  endtask
  // fixed wait: move lands two edges after the request, readback one later
  task automatic step_go(input logic dr, input int n);
    step = 1'b1;
    dir = dr;
    @(posedge clk);
    #1 step = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    step = 1'b0;
    dir = 1'b0;
    addr = 7'h00;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_reg(7'h6A, d); chk(d, 32'h0);
    rd_reg(7'h6B, d); chk(d, 32'h00F7_0000);
    rd_reg(7'h6C, d); chk(d, 32'h1041_0150);
    wr_reg(7'h6C, 32'hDFFF_FFFF); // bit 29 left clear
    rd_reg(7'h6C, d); chk(d, 32'hDFFD_DFFF);
    chk(cfg, 32'hDFFD_DFFF);
    chk(32'({sg, gg, ie}), 32'h7);
    wr_reg(7'h6A, 32'hFFFF_FFFF);
    wr_reg(7'h6B, 32'hFFFF_FFFF);
    rd_reg(7'h6A, d); chk(d, 32'h0);
    rd_reg(7'h10, d); chk(d, 32'h0);
    wr_reg(7'h6C, 32'h0);
    chk(32'({sg, gg, ie, res}), 32'h0);
    step_go(1'b1, 3);
    rd_reg(7'h6B, d); chk(d, 32'h0154_0101);
    step_go(1'b0, 3);
    step_go(1'b0, 3);
    rd_reg(7'h6A, d); chk(d, 32'h3FF);
    step_go(1'b1, 3);
    rd_reg(7'h6B, d); chk(d, 32'h00A5_003C);
    chk(32'(ib), 32'h100);
    for (int k = 0; k <= 8; k++) begin
      wr_reg(7'h6C, {4'h0, 4'(k), 24'h0});
      rd_reg(7'h6A, p);
      step_go(1'b1, 3);
      rd_reg(7'h6A, d); chk(d, {22'h0, p[9:0] + (10'h1 << k)});
    end
    // four unit moves at two clocks each, plus pipeline margin
    wr_reg(7'h6C, 32'h1200_0000);
    rd_reg(7'h6A, p);
    step_go(1'b1, 16);
    rd_reg(7'h6A, d); chk(d, {22'h0, p[9:0] + 10'h4});
    wrap_up();
  end
endmodule
